// [design/adc_sample_output_port.sv]
// Purpose: digital sampling and parallel result output of a 10-bit converter
// Assumes: analog input modelled as signed lsb count around mid-scale
// Notes: result appears one cycle after the sampling edge
`timescale 1ns/1ps
// Functional notes
// - sample input on every rising clock edge
// - output word one cycle after sample
// - 10-bit straight binary, zero is negative end
// - overrange high when one lsb above full-scale
// - code all ones while overrange high
module adc_sample_output_port
(
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic signed [adc_sample_pkg::IN_WIDTH-1:0] analog_sample_input,
	output logic [adc_sample_pkg::CODE_WIDTH-1:0] sample_code_out,
	output logic overrange_flag_out
);
	import adc_sample_pkg::*;

	sample_if smp ();
	result_t res_ff;
	result_t nxt_res;
	range_t rng;

	// track-and-hold stage, sampled on every rising edge
	adc_track_hold adc_track_hold_inst (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.analog_sample_input(analog_sample_input),
		.smp(smp)
	);

	function automatic range_t classify(input logic signed [IN_WIDTH-1:0] v);
		if (v >= IN_POS_FS + IN_OVR_LSB) begin
			classify = RANGE_OVER;
		end else if (v < IN_NEG_FS) begin
			classify = RANGE_UNDER;
		end else begin
			classify = RANGE_IN;
		end
	endfunction

	function automatic logic [CODE_WIDTH-1:0] to_binary(input logic signed [IN_WIDTH-1:0] v);
		logic signed [IN_WIDTH-1:0] off;
		off = v - IN_NEG_FS;
		to_binary = off[CODE_WIDTH-1:0];
	endfunction

	// check-only reference: offset binary is two's complement with the top bit flipped
	function automatic result_t ref_word(input logic signed [IN_WIDTH-1:0] v);
		result_t w;
		w.overrange = (v > IN_POS_FS);
		if (w.overrange) begin
			w.code = CODE_MAX;
		end else if (v < IN_NEG_FS) begin
			w.code = CODE_MIN;
		end else begin
			w.code = {~v[CODE_WIDTH-1], v[CODE_WIDTH-2:0]};
		end
		return w;
	endfunction

	always_comb begin
		rng = classify(smp.held);
		nxt_res.overrange = 1'b0;
		nxt_res.code = CODE_MIN;
		case (rng)
			RANGE_OVER: begin
				nxt_res.overrange = 1'b1;
				nxt_res.code = CODE_MAX;
			end
			RANGE_UNDER: begin
				nxt_res.code = CODE_MIN;
			end
			default: begin
				nxt_res.code = to_binary(smp.held);
			end
		endcase
	end

	// output latch updates on the edge after the sample edge
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			res_ff <= '{overrange: 1'b0, code: CODE_RESET};
		end else if (smp.valid) begin
			res_ff <= nxt_res;
		end
	end

	// both fields from one register so they move together
	assign sample_code_out = res_ff.code;
	assign overrange_flag_out = res_ff.overrange;

	// input one sample ago, for checking the hold stage
	logic signed [IN_WIDTH-1:0] in_d1_ff;
	logic [1:0] age_ff;
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			in_d1_ff <= '0;
		end else begin
			in_d1_ff <= analog_sample_input;
		end
	end

	// edges since reset, saturating; 3 means two samples of history
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			age_ff <= 2'h0;
		end else if (age_ff != 2'h3) begin
			age_ff <= age_ff + 2'h1;
		end
	end

	property p_sample_each_edge;
		@(posedge sys_clk) disable iff (!rst_n)
		age_ff >= 2'h1 |-> smp.held == in_d1_ff;
	endproperty
	a_sample_each_edge: assert property (p_sample_each_edge) else $error("held value not last input");

	property p_latency;
		@(posedge sys_clk) disable iff (!rst_n)
		(age_ff == 2'h3) && ($past(analog_sample_input, 2) >= IN_NEG_FS)
			&& ($past(analog_sample_input, 2) <= IN_POS_FS)
		|-> sample_code_out == to_binary($past(analog_sample_input, 2));
	endproperty
	a_latency: assert property (p_latency) else $error("output code wrong or late");

	property p_zero_code;
		@(posedge sys_clk) disable iff (!rst_n)
		(age_ff == 2'h3) && ($past(analog_sample_input, 2) <= IN_NEG_FS) |-> sample_code_out == CODE_MIN;
	endproperty
	a_zero_code: assert property (p_zero_code) else $error("negative end not zero code");

	property p_overrange_flag;
		@(posedge sys_clk) disable iff (!rst_n)
		age_ff == 2'h3 |-> overrange_flag_out == ($past(analog_sample_input, 2) > IN_POS_FS);
	endproperty
	a_overrange_flag: assert property (p_overrange_flag) else $error("overrange flag mismatch");

	property p_overrange_code;
		@(posedge sys_clk) disable iff (!rst_n)
		overrange_flag_out |-> sample_code_out == CODE_MAX;
	endproperty
	a_overrange_code: assert property (p_overrange_code) else $error("code not max during overrange");

	property p_word_together;
		@(posedge sys_clk) disable iff (!rst_n)
		$rose(overrange_flag_out) |-> $past(smp.held) > IN_POS_FS;
	endproperty
	a_word_together: assert property (p_word_together) else $error("flag rose without overrange sample");

	// no result may show before the first sample has passed the output stage
	property p_first_word_quiet;
		@(posedge sys_clk) disable iff (!rst_n)
		age_ff == 2'h1 |-> (sample_code_out == CODE_RESET) && !overrange_flag_out;
	endproperty
	a_first_word_quiet: assert property (p_first_word_quiet) else $error("output moved before first result");

	property p_held_valid;
		@(posedge sys_clk) disable iff (!rst_n)
		age_ff != 2'h0 |-> smp.valid;
	endproperty
	a_held_valid: assert property (p_held_valid) else $error("hold stage not valid after first edge");

	property p_valid_holds;
		@(posedge sys_clk) disable iff (!rst_n)
		smp.valid |=> smp.valid;
	endproperty
	a_valid_holds: assert property (p_valid_holds) else $error("hold stage dropped valid");

	property p_word_ref;
		@(posedge sys_clk) disable iff (!rst_n)
		age_ff == 2'h3 |-> {overrange_flag_out, sample_code_out} == ref_word($past(analog_sample_input, 2));
	endproperty
	a_word_ref: assert property (p_word_ref) else $error("output word differs from reference");

	property p_stage_latency;
		@(posedge sys_clk) disable iff (!rst_n)
		age_ff == 2'h3 |-> {overrange_flag_out, sample_code_out} == ref_word($past(smp.held));
	endproperty
	a_stage_latency: assert property (p_stage_latency) else $error("output stage not one cycle behind hold");

	property p_under_clamp;
		@(posedge sys_clk) disable iff (!rst_n)
		(age_ff == 2'h3) && ($past(analog_sample_input, 2) < IN_NEG_FS)
		|-> (sample_code_out == CODE_MIN) && !overrange_flag_out;
	endproperty
	a_under_clamp: assert property (p_under_clamp) else $error("input below range not clamped to zero");

	property p_top_code;
		@(posedge sys_clk) disable iff (!rst_n)
		(age_ff == 2'h3) && ($past(analog_sample_input, 2) == IN_POS_FS)
		|-> (sample_code_out == CODE_MAX) && !overrange_flag_out;
	endproperty
	a_top_code: assert property (p_top_code) else $error("top code raised the flag");

	property p_flag_from_sample;
		@(posedge sys_clk) disable iff (!rst_n)
		overrange_flag_out |-> $past(smp.held) > IN_POS_FS;
	endproperty
	a_flag_from_sample: assert property (p_flag_from_sample) else $error("flag high without overrange sample");

	property p_flag_falls;
		@(posedge sys_clk) disable iff (!rst_n)
		$fell(overrange_flag_out) |-> $past(smp.held) <= IN_POS_FS;
	endproperty
	a_flag_falls: assert property (p_flag_falls) else $error("flag fell while sample still over range");

	property p_flag_stays;
		@(posedge sys_clk) disable iff (!rst_n)
		overrange_flag_out && $past(overrange_flag_out) |-> $stable(sample_code_out);
	endproperty
	a_flag_stays: assert property (p_flag_stays) else $error("code moved while flag stayed high");

	// main scenarios
	c_overrange: cover property (@(posedge sys_clk) disable iff (!rst_n) $rose(overrange_flag_out));
	c_full_span: cover property (@(posedge sys_clk) disable iff (!rst_n)
		sample_code_out == CODE_MIN ##1 sample_code_out == CODE_MAX);
	c_in_range: cover property (@(posedge sys_clk) disable iff (!rst_n)
		overrange_flag_out ##1 !overrange_flag_out && sample_code_out != CODE_MAX);
	c_under_range: cover property (@(posedge sys_clk) disable iff (!rst_n)
		sample_code_out == CODE_MIN && $past(analog_sample_input, 2) < IN_NEG_FS);
	c_top_code: cover property (@(posedge sys_clk) disable iff (!rst_n)
		sample_code_out == CODE_MAX && !overrange_flag_out);
endmodule

// [design/adc_track_hold.sv]
// Purpose: samples the analog input value on each rising edge
// Assumes: input already in the clock domain of the converter model
// Notes: valid rises after the first sample edge
`timescale 1ns/1ps
module adc_track_hold
(
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic signed [adc_sample_pkg::IN_WIDTH-1:0] analog_sample_input,
	sample_if.hold smp
);
	import adc_sample_pkg::*;

	logic signed [IN_WIDTH-1:0] held_ff;
	logic valid_ff;

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			held_ff <= '0;
		end else begin
			held_ff <= analog_sample_input;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			valid_ff <= 1'b0;
		end else begin
			valid_ff <= 1'b1;
		end
	end

	assign smp.held = held_ff;
	assign smp.valid = valid_ff;
endmodule

// [include/adc_sample_pkg.sv]
// Purpose: shared constants and types for the sample output port
// Assumes: digital model of the converter, analog input as a signed digital value
// Notes: input quantised to code_width plus headroom bits
package adc_sample_pkg;
	localparam int CODE_WIDTH = 10;
	localparam int IN_WIDTH = 12;
	// analog input as signed count of lsb relative to mid-scale
	localparam logic signed [IN_WIDTH-1:0] IN_NEG_FS = -12'sd512;
	localparam logic signed [IN_WIDTH-1:0] IN_POS_FS = 12'sd511;
	localparam logic signed [IN_WIDTH-1:0] IN_OVR_LSB = 12'sd1;
	localparam logic [CODE_WIDTH-1:0] CODE_MAX = 10'h3FF;
	localparam logic [CODE_WIDTH-1:0] CODE_MIN = 10'h000;
	localparam logic [CODE_WIDTH-1:0] CODE_RESET = 10'h000;
	localparam real CLK_PERIOD_NS = 40.0;
	localparam real CLK_HIGH_MIN_NS = 10.0;
	localparam real CLK_HIGH_MAX_NS = 300.0;
	localparam real CLK_LOW_MIN_NS = 10.0;
	localparam real DUTY_RATE_MSPS = 3.0;
	localparam int LATENCY_CYCLES = 1;
	typedef enum logic [1:0] {RANGE_UNDER, RANGE_IN, RANGE_OVER} range_t;
	typedef struct packed {
		logic overrange;
		logic [CODE_WIDTH-1:0] code;
	} result_t;
endpackage

// [include/sample_if.sv]
// Purpose: carries a held sample between the hold stage and the output stage
// Assumes: one clock domain
// Notes: valid marks a held sample
`timescale 1ns/1ps
interface sample_if;
	import adc_sample_pkg::*;
	logic signed [IN_WIDTH-1:0] held;
	logic valid;
	modport hold (output held, output valid);
	modport conv (input held, input valid);
endinterface

// [verif/capture_model.sv]
// Purpose: capture logic latching each result word
// Assumes: outputs settled well before the falling edge
// Notes: code and flag taken together as one word
`timescale 1ns/1ps
module capture_model
(
	input wire logic sys_clk,
	input wire logic [adc_sample_pkg::CODE_WIDTH-1:0] sample_code_out,
	input wire logic overrange_flag_out,
	output adc_sample_pkg::result_t captured_ff
);
	import adc_sample_pkg::*;

	always_ff @(negedge sys_clk) begin
		captured_ff <= {overrange_flag_out, sample_code_out};
	end
endmodule

// [verif/tb_adc_sample_output_port.sv]
// Purpose: self-checking bench for the sample output port
// Assumes: capture model latches on the falling edge
// Notes: each word checked two edges after its drive
`timescale 1ns/1ps
module tb_adc_sample_output_port;
	import adc_sample_pkg::*;
	typedef logic signed [IN_WIDTH-1:0] vec_t [6];
	logic sys_clk = 1'b0;
	logic rst_n = 1'b0;
	logic signed [IN_WIDTH-1:0] analog_sample_input = '0;
	logic [CODE_WIDTH-1:0] sample_code_out;
	logic overrange_flag_out;
	result_t captured;
	int fail_count = 0;
	int check_count = 0;
	always #(CLK_PERIOD_NS / 2.0) sys_clk = ~sys_clk;
	adc_sample_output_port adc_sample_output_port_inst (.sys_clk(sys_clk), .rst_n(rst_n),
		.analog_sample_input(analog_sample_input), .sample_code_out(sample_code_out),
		.overrange_flag_out(overrange_flag_out));
	capture_model capture_model_inst (.sys_clk(sys_clk), .sample_code_out(sample_code_out),
		.overrange_flag_out(overrange_flag_out), .captured_ff(captured));
	function automatic result_t expect_word(logic signed [IN_WIDTH-1:0] x);
		result_t w;
		logic [IN_WIDTH-1:0] ofs;
		ofs = x - IN_NEG_FS;
		w.overrange = (x > IN_POS_FS);
		w.code = w.overrange ? CODE_MAX : (x < IN_NEG_FS) ? CODE_MIN : ofs[CODE_WIDTH-1:0];
		return w;
	endfunction
	task automatic compare(result_t got, result_t exp);
		check_count++;
		if (got !== exp) begin
			fail_count++;
			$display("unexpected at %0t: word %h, expected %h", $time, got, exp);
		end
	endtask
	// back to back samples, result two edges later at the capture
	task automatic feed(vec_t v);
		for (int i = 0; i < 8; i++) begin
			@(posedge sys_clk);
			#1;
			if (i < 6) analog_sample_input = v[i];
			@(negedge sys_clk);
			#1;
			if (i >= 2) compare(captured, expect_word(v[i-2]));
		end
	endtask
	task automatic test_range;
		feed('{-512, -511, -1, 0, 510, 511});
		$display("test range done");
	endtask
	task automatic test_overrange;
		feed('{511, 512, 513, 2047, -512, 512});
		$display("test overrange done");
	endtask
	task automatic test_below;
		feed('{-513, -2048, 511, -512, 512, 0});
		$display("test below range done");
	endtask
	// mid-run reset clears the word, then sampling resumes
	task automatic test_reset;
		@(posedge sys_clk);
		#1;
		analog_sample_input = 12'sd512;
		repeat (2) @(posedge sys_clk);
		#1;
		rst_n = 1'b0;
		@(negedge sys_clk);
		#1;
		compare(captured, '{overrange: 1'b0, code: CODE_RESET});
		@(posedge sys_clk);
		#1;
		rst_n = 1'b1;
		feed('{-512, 511, 512, 0, -1, 1});
		$display("test reset done");
	endtask
	task automatic give_verdict;
		$display("checks %0d, mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	initial begin
		repeat (16) @(posedge sys_clk);
		#1;
		rst_n = 1'b1;
		test_range;
		test_overrange;
		test_below;
		test_reset;
		give_verdict;
	end
endmodule
